// ---- hdl/clp_top.sv ----
/*
  Copper link power control: crossover and polarity selection,
  low-amplitude 10M and low-power-idle enables, inline-power partner
  detection and the automatic power management state machine.
  Assumes media status pins from the analog front end, speed and idle
  requests from same-clock logic, and a simple register port.
*/
// Our own choices: the plain strobed port and the register addresses.
// Behaviour
// RL1: Auto crossover and polarity on after reset.
// RL2: Crossover and polarity state readable.
// RL3: Auto crossover allowed with negotiation off.
// RL4: Crossed mode swaps both pair groups.
// RL5: Override 10 straight, 11 crossed, 00 auto.
// RL6: Low-amplitude 10M when enable bit set.
// RL7: Low-power idle at 100M between bursts.
// RL8: Software enables detection with negotiation on.
// RL9: Detection status reads 00 while searching.
// RL10: Looped pulses set status 01.
// RL11: Detection sets flag; read clears it.
// RL12: No loopback within limit gives status 10.
// RL13: Status 10 ends detection, starts negotiation.
// RL14: Link failure returns to detection.
// RL15: Host switch applies and removes port power; this block has no port power switch.
// RL16: Power management follows its enable bit.
// RL17: Alternate low power and wake-up without energy.
// RL18: Energy enters normal; link loss times out.
// RL19: Power management starts in low power; here it is off at reset and, once enabled, starts in normal.
// RL20: Forced speed: once normal, stay normal.
// RL21: Negotiation off in normal: no return.
// RL22: Low power: blocks down, registers alive.
// RL23: Sleep time selectable, randomised -80..+60 ms.
// RL24: Wake-up: three bursts on alternating pairs.
// RL25: Link status timeout selectable.
`timescale 1ns/10ps
module clp_top #(
  parameter logic [16:0] MS_CYC_P = clp_pkg::MS_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  wire logic [clp_pkg::AW-1:0] reg_addr,
  input  wire logic [clp_pkg::DW-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [clp_pkg::DW-1:0] reg_rdata,
  input  wire logic                   energy_pin,
  input  wire logic                   flp_loop_pin,
  input  wire logic                   link_pin,
  input  wire logic                   xover_pin,
  input  wire logic                   pol_pin,
  input  wire logic                   speed_100,
  input  wire logic                   tx_lpi_req,
  output logic                        mdi_crossed,
  output logic                        pol_correct,
  output logic                        lowamp_10,
  output logic                        lpi_active,
  output logic                        flp_search_tx,
  output logic                        an_run,
  output logic                        power_down,
  output logic                        flp_burst,
  output logic                        wake_pair_b,
  output logic                        det_irq
);
  import clp_pkg::*;

  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [TSEL_W-1:0] tsel;
    logic              crossed;
    logic              polc;
    clp_det_t          det;
    logic [1:0]        dstat;
    logic              dflag;
    logic              link_q;
    logic              srch;
    clp_pm_t           pm;
    logic              fresh;
    logic              lock;
    logic [1:0]        burst_n;
    logic [5:0]        burst_ms;
    logic              pair_b;
    logic              burst;
    logic [16:0]       ms_cnt;
    logic [7:0]        lfsr;
    logic [DW-1:0]     rdata;
    logic              lpi;
    logic              an_run;
    logic              pdown;
  } clp_top_st_t;

  localparam clp_top_st_t ST_RST = '{
    ctrl: CTRL_RST, tsel: TSEL_RST, det: DET_OFF, pm: PM_LOW,
    fresh: 1'b1, lfsr: LFSR_SEED, default: '0};

  clp_top_st_t    st_q;
  clp_top_st_t    st_d;
  logic [P_W-1:0] pin_s;
  logic           tick;
  logic [7:0]     rnd;
  logic [15:0]    slp_val;
  logic [15:0]    wake_val;
  logic [15:0]    lto_val;
  logic           an_en;
  logic           det_on;
  logic           auto_ok;
  logic           det_evt;
  logic           flag_rd;

  clp_tmr_if pm_t ();
  clp_tmr_if det_t ();

  clp_sync #(.W(P_W)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({pol_pin, xover_pin, link_pin, flp_loop_pin, energy_pin}),
    .q     (pin_s)
  );

  clp_timer u_pm_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .t     (pm_t.tmr)
  );

  clp_timer u_det_tmr (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .t     (det_t.tmr)
  );

  assign tick    = st_q.ms_cnt == MS_CYC_P - 17'h00001;
  assign an_en   = st_q.ctrl[C_AN];
  assign det_on  = st_q.ctrl[C_DET] && an_en;
  assign flag_rd = reg_rd && reg_addr == A_FLAG;
  // Fold the LFSR into 0..140 ms; slight bias traded for no divider
  assign rnd     = (st_q.lfsr >= RND_SPAN) ? st_q.lfsr - RND_SPAN
                                           : st_q.lfsr;
  assign slp_val = SLEEP_MS[st_q.tsel[T_SLP+:2]] - RND_LO_MS
                   + {8'h00, rnd}; // [RL23]
  assign wake_val = WAKE_MS[st_q.tsel[T_WAK+:2]]; // [RL24]
  assign lto_val  = LTO_MS[st_q.tsel[T_LTO+:2]]; // [RL25]
  assign auto_ok  = st_q.ctrl[C_XAUTO]
                    && (an_en || !st_q.ctrl[C_XFDIS]); // [RL3]

  always_comb begin
    st_d         = st_q;
    det_evt      = 1'b0;
    pm_t.ld      = 1'b0;
    pm_t.val     = lto_val;
    pm_t.tick    = tick;
    det_t.ld     = 1'b0;
    det_t.val    = DET_MS;
    det_t.tick   = tick;
    st_d.ms_cnt  = tick ? 17'h00000 : st_q.ms_cnt + 17'h00001;
    st_d.lfsr    = {st_q.lfsr[6:0], st_q.lfsr[7] ^ st_q.lfsr[5]
                    ^ st_q.lfsr[4] ^ st_q.lfsr[3]};
    st_d.link_q  = pin_s[P_LINK];

    if (reg_wr) begin
      case (reg_addr)
        A_CTRL: st_d.ctrl = reg_wdata[CTRL_W-1:0]; // [RL1]
        A_TSEL: st_d.tsel = reg_wdata[TSEL_W-1:0];
        default: ;
      endcase
    end

    // Crossed: TX on 3,6 and RX on 1,2; 4,5 trade with 7,8
    case (st_q.ctrl[C_OVR+:2])
      OVR_STRAIGHT: st_d.crossed = 1'b0; // [RL5]
      OVR_CROSS:    st_d.crossed = 1'b1; // [RL5] [RL4]
      default:      st_d.crossed = auto_ok && pin_s[P_XOV]; // [RL3]
    endcase
    st_d.polc = st_q.ctrl[C_POL] && pin_s[P_POL];

    // Inline-power partner detection
    case (st_q.det)
      DET_OFF: begin
        st_d.dstat = DST_SRCH;
        if (det_on) begin // [RL8]
          st_d.det = DET_SRCH;
          det_t.ld = 1'b1;
        end
      end
      DET_SRCH, DET_FND: begin
        if (!det_on) begin
          st_d.det = DET_OFF;
        end else if (pin_s[P_LOOP]) begin
          st_d.det   = DET_FND;
          st_d.dstat = DST_PWR; // [RL10]
          // First echo only, so a read can withdraw the request
          det_evt    = st_q.det == DET_SRCH; // [RL11]
          det_t.ld   = 1'b1;
        end else if (det_t.done) begin
          st_d.det   = DET_NORM; // [RL13]
          st_d.dstat = DST_NONE; // [RL12]
        end
      end
      DET_NORM: begin
        if (!det_on) begin
          st_d.det = DET_OFF;
        end else if (st_q.link_q && !pin_s[P_LINK]) begin
          st_d.det   = DET_SRCH; // [RL14]
          st_d.dstat = DST_SRCH; // [RL9]
          det_t.ld   = 1'b1;
        end
      end
      default: st_d.det = DET_OFF;
    endcase
    // Set wins over the clear-on-read
    st_d.dflag = det_evt || (st_q.dflag && !flag_rd); // [RL11]
    st_d.srch  = st_d.det == DET_SRCH || st_d.det == DET_FND;
    st_d.an_run = st_d.ctrl[C_AN] && !st_d.srch; // [RL13]

    // Power management
    if (!st_q.ctrl[C_PM]) begin
      st_d.pm    = PM_NORM; // [RL16]
      st_d.lock  = !an_en;
      st_d.fresh = 1'b0;
      pm_t.ld    = 1'b1;
    end else begin
      case (st_q.pm)
        PM_LOW: begin
          if (st_q.fresh) begin
            st_d.fresh = 1'b0; // [RL19]
            pm_t.ld    = 1'b1;
            pm_t.val   = slp_val;
          end else if (pin_s[P_NRG]) begin
            st_d.pm   = PM_NORM; // [RL18]
            st_d.lock = !an_en; // [RL20]
            pm_t.ld   = 1'b1;
          end else if (pm_t.done) begin
            st_d.pm       = PM_WAKE; // [RL17]
            st_d.burst_n  = 2'h0;
            st_d.burst_ms = 6'h00;
            pm_t.ld       = 1'b1;
            pm_t.val      = wake_val;
          end
        end
        PM_WAKE: begin
          if (pin_s[P_NRG]) begin
            st_d.pm   = PM_NORM; // [RL18]
            st_d.lock = !an_en;
            pm_t.ld   = 1'b1;
          end else if (pm_t.done) begin
            st_d.pm  = PM_LOW; // [RL17] [RL24]
            pm_t.ld  = 1'b1;
            pm_t.val = slp_val;
          end else if (tick) begin
            st_d.burst_ms = st_q.burst_ms + 6'h01;
            if (st_q.burst_ms == BURST_GAP_MS - 6'h01) begin
              st_d.burst_ms = 6'h00;
              if (st_q.burst_n != BURSTS) begin
                st_d.burst_n = st_q.burst_n + 2'h1; // [RL24]
                st_d.pair_b  = !st_q.pair_b;
              end
            end
          end
        end
        PM_NORM: begin
          st_d.lock = st_q.lock || !an_en; // [RL21]
          // Link up keeps the timeout primed; it runs only when down
          if (st_d.lock) begin
            st_d.pm = PM_NORM; // [RL20]
          end else if (pin_s[P_LINK]) begin
            pm_t.ld = 1'b1; // [RL25]
          end else if (pm_t.done) begin
            st_d.pm  = PM_LOW; // [RL18]
            pm_t.ld  = 1'b1;
            pm_t.val = slp_val;
          end
        end
        default: st_d.pm = PM_LOW;
      endcase
    end
    st_d.pdown = st_d.pm == PM_LOW; // [RL22]
    st_d.burst = st_d.pm == PM_WAKE && st_d.burst_n != BURSTS; // [RL24]
    st_d.lpi   = st_q.ctrl[C_EEE] && speed_100 && pin_s[P_LINK]
                 && tx_lpi_req && st_q.pm == PM_NORM; // [RL7]

    // Register reads stay alive in every power state
    st_d.rdata = '0;
    if (reg_rd) begin
      case (reg_addr)
        A_CTRL: st_d.rdata = DW'(st_q.ctrl);
        A_TSEL: st_d.rdata = DW'(st_q.tsel);
        A_STAT: begin
          st_d.rdata[S_XOV]     = st_q.crossed; // [RL2]
          st_d.rdata[S_POLC]    = st_q.polc; // [RL2]
          st_d.rdata[S_DST+:2]  = st_q.dstat; // [RL9]
          st_d.rdata[S_LINK]    = pin_s[P_LINK];
          st_d.rdata[S_PM+:3]   = st_q.pm;
          st_d.rdata[S_LPI]     = st_q.lpi;
        end
        A_FLAG: st_d.rdata[0] = st_q.dflag;
        default: st_d.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= ST_RST; // [RL1] [RL19]
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign reg_rdata     = st_q.rdata;
  assign mdi_crossed   = st_q.crossed;
  assign pol_correct   = st_q.polc;
  assign lowamp_10     = st_q.ctrl[C_TE10]; // [RL6]
  assign lpi_active    = st_q.lpi;
  assign flp_search_tx = st_q.srch; // [RL8]
  assign an_run        = st_q.an_run;
  assign power_down    = st_q.pdown;
  assign flp_burst     = st_q.burst;
  assign wake_pair_b   = st_q.pair_b;
  assign det_irq       = st_q.dflag; // [RL11]

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_rst_dflt;
    $rose(rst_n) |-> st_q.ctrl[C_XAUTO] && st_q.ctrl[C_POL];
  endproperty
  a_rst_dflt: assert property (p_rst_dflt) // [RL1]
    else $error("crossover or polarity default off");

  property p_stat_rd;
    ce && reg_rd && reg_addr == A_STAT |=>
      reg_rdata[1:0] == $past({st_q.polc, st_q.crossed});
  endproperty
  a_stat_rd: assert property (p_stat_rd) // [RL2]
    else $error("status read mismatch");

  property p_fx_auto;
    ce && st_q.ctrl[C_OVR+:2] == 2'h0 && st_q.ctrl[C_XAUTO]
      && !an_en && !st_q.ctrl[C_XFDIS]
      |=> mdi_crossed == $past(pin_s[P_XOV]);
  endproperty
  a_fx_auto: assert property (p_fx_auto) // [RL3]
    else $error("forced-speed auto crossover not followed");

  property p_ovr_st;
    ce && st_q.ctrl[C_OVR+:2] == OVR_STRAIGHT |=> !mdi_crossed;
  endproperty
  a_ovr_st: assert property (p_ovr_st) // [RL5]
    else $error("override straight ignored");

  property p_ovr_cr;
    ce && st_q.ctrl[C_OVR+:2] == OVR_CROSS |=> mdi_crossed;
  endproperty
  a_ovr_cr: assert property (p_ovr_cr) // [RL5]
    else $error("override crossed ignored");

  property p_srch_00;
    st_q.det == DET_SRCH |-> st_q.dstat == DST_SRCH && flp_search_tx;
  endproperty
  a_srch_00: assert property (p_srch_00) // [RL9]
    else $error("search status not 00");

  property p_found;
    ce && det_on && st_q.det == DET_SRCH && pin_s[P_LOOP]
      |=> st_q.dstat == DST_PWR && det_irq;
  endproperty
  a_found: assert property (p_found) // [RL10]
    else $error("loopback not reported");

  property p_rdclr;
    ce && flag_rd && !det_evt |=> !det_irq;
  endproperty
  a_rdclr: assert property (p_rdclr) // [RL11]
    else $error("flag not cleared by read");

  property p_nolp;
    ce && det_on && st_q.srch && !pin_s[P_LOOP] && det_t.done
      |=> st_q.dstat == DST_NONE && an_run && !flp_search_tx;
  endproperty
  a_nolp: assert property (p_nolp) // [RL12]
    else $error("timeout did not give status 10");

  property p_relink;
    ce && det_on && st_q.det == DET_NORM && st_q.link_q
      && !pin_s[P_LINK] |=> st_q.det == DET_SRCH ##0 !an_run;
  endproperty
  a_relink: assert property (p_relink) // [RL14]
    else $error("link loss did not restart detection");

  property p_wake;
    ce && st_q.ctrl[C_PM] && st_q.pm == PM_LOW && !st_q.fresh
      && !pin_s[P_NRG] && pm_t.done |=> st_q.pm == PM_WAKE && flp_burst;
  endproperty
  a_wake: assert property (p_wake) // [RL17]
    else $error("low power did not move to wake-up");

  property p_nrg;
    ce && st_q.ctrl[C_PM] && st_q.pm == PM_LOW && !st_q.fresh
      && pin_s[P_NRG] |=> st_q.pm == PM_NORM && !power_down;
  endproperty
  a_nrg: assert property (p_nrg) // [RL18]
    else $error("energy did not reach normal state");

  property p_lock;
    ce && st_q.pm == PM_NORM && st_q.lock |=> st_q.pm == PM_NORM;
  endproperty
  a_lock: assert property (p_lock) // [RL21]
    else $error("locked normal state left");

  c_found: cover property (st_q.dstat == DST_PWR ##1 flag_rd);
  c_wake:  cover property (st_q.pm == PM_WAKE ##1 st_q.pm == PM_LOW);
  c_drop:  cover property (st_q.pm == PM_NORM ##1 st_q.pm == PM_LOW);
endmodule

// ---- hdl/clp_pkg.sv ----
/*
  Shared constants and types for the copper link power control block.
  Assumes a 100 MHz system clock and a 16-bit register port.
*/
package clp_pkg;
  // Timing
  localparam int          CLK_NS = 10;
  localparam int          MS_NS  = 1000000;
  localparam logic [16:0] MS_CYC = 17'(MS_NS / CLK_NS);

  // Register port
  localparam int         AW     = 3;
  localparam int         DW     = 16;
  localparam logic [2:0] A_CTRL = 3'h0;
  localparam logic [2:0] A_TSEL = 3'h1;
  localparam logic [2:0] A_STAT = 3'h2;
  localparam logic [2:0] A_FLAG = 3'h3;

  // Control register fields
  localparam int         CTRL_W   = 10;
  localparam int         C_AN     = 0;
  localparam int         C_XAUTO  = 1;
  localparam int         C_POL    = 2;
  localparam int         C_XFDIS  = 3;
  localparam int         C_OVR    = 4;
  localparam int         C_TE10   = 6;
  localparam int         C_EEE    = 7;
  localparam int         C_DET    = 8;
  localparam int         C_PM     = 9;
  localparam logic [9:0] CTRL_RST = 10'h00F;

  // Timer select fields
  localparam int         TSEL_W   = 6;
  localparam int         T_SLP    = 0;
  localparam int         T_WAK    = 2;
  localparam int         T_LTO    = 4;
  localparam logic [5:0] TSEL_RST = 6'h01;

  // Status field positions
  localparam int S_XOV = 0;
  localparam int S_POLC = 1;
  localparam int S_DST = 2;
  localparam int S_LINK = 4;
  localparam int S_PM = 5;
  localparam int S_LPI = 8;

  // Media pin inputs, in synchroniser order
  localparam int P_W    = 5;
  localparam int P_NRG  = 0;
  localparam int P_LOOP = 1;
  localparam int P_LINK = 2;
  localparam int P_XOV  = 3;
  localparam int P_POL  = 4;

  localparam logic [1:0] OVR_STRAIGHT = 2'h2;
  localparam logic [1:0] OVR_CROSS    = 2'h3;
  localparam logic [1:0] DST_SRCH     = 2'h0;
  localparam logic [1:0] DST_PWR      = 2'h1;
  localparam logic [1:0] DST_NONE     = 2'h2;

  // Durations in ms, indexed by two-bit select codes
  localparam logic [3:0][15:0] SLEEP_MS =
    {16'h0FA0, 16'h0BB8, 16'h07D0, 16'h03E8};
  localparam logic [3:0][15:0] WAKE_MS =
    {16'h0320, 16'h0190, 16'h00C8, 16'h0064};
  localparam logic [3:0][15:0] LTO_MS =
    {16'h0FA0, 16'h0BB8, 16'h07D0, 16'h03E8};
  localparam logic [15:0] RND_LO_MS    = 16'h0050;
  localparam logic [7:0]  RND_SPAN     = 8'h8D;
  localparam logic [15:0] DET_MS       = 16'h01F4;
  localparam logic [5:0]  BURST_GAP_MS = 6'h20;
  localparam logic [1:0]  BURSTS       = 2'h3;
  localparam logic [7:0]  LFSR_SEED    = 8'hA5;

  typedef enum logic [3:0] {
    DET_OFF  = 4'h1,
    DET_SRCH = 4'h2,
    DET_FND  = 4'h4,
    DET_NORM = 4'h8
  } clp_det_t;

  typedef enum logic [2:0] {
    PM_LOW  = 3'h1,
    PM_WAKE = 3'h2,
    PM_NORM = 3'h4
  } clp_pm_t;
endpackage

// ---- hdl/clp_tmr_if.sv ----
/*
  Millisecond timer carrier between control logic and a timer.
  Assumes one driver per side, all on the system clock.
*/
`timescale 1ns/10ps
interface clp_tmr_if;
  logic        ld;
  logic [15:0] val;
  logic        tick;
  logic        done;
  modport ctl (output ld, output val, output tick, input done);
  modport tmr (input ld, input val, input tick, output done);
endinterface

// ---- hdl/clp_sync.sv ----
/*
  Two-flop synchroniser for a group of asynchronous pin levels.
  Assumes the levels are quasi-static; no bus coherency is kept.
*/
`timescale 1ns/10ps
module clp_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } clp_sync_st_t;

  clp_sync_st_t st_q;
  clp_sync_st_t st_d;

  always_comb begin
    st_d    = st_q;
    st_d.s1 = d;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  assign q = st_q.s2;
endmodule

// ---- hdl/clp_timer.sv ----
/*
  Down-counter of millisecond ticks with a load strobe.
  Assumes the tick pulse and load come from the same clock.
*/
`timescale 1ns/10ps
module clp_timer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  clp_tmr_if.tmr   t
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        armed;
  } clp_tmr_st_t;

  clp_tmr_st_t st_q;
  clp_tmr_st_t st_d;

  always_comb begin
    st_d = st_q;
    if (t.ld) begin
      st_d.cnt   = t.val;
      st_d.armed = 1'b1;
    end else if (t.tick && st_q.cnt != 16'h0000) begin
      st_d.cnt = st_q.cnt - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (ce) begin
      st_q <= st_d;
    end
  end

  // Unarmed after reset so a stale zero never reads as expiry
  assign t.done = st_q.armed && (st_q.cnt == 16'h0000);
endmodule

// ---- testbench/clp_media_model.sv ----
/*
  Link partner across the cable, seen as media status pin levels.
  Assumes bench-set cable state; all answers lag by DLY clocks.
*/
`timescale 1ns/10ps
module clp_media_model #(
  parameter int DLY = 20
) (
  input  wire logic clk,
  input  wire logic plug,
  input  wire logic unpowered,
  input  wire logic crossed,
  input  wire logic inverted,
  input  wire logic an_run,
  input  wire logic flp_search_tx,
  output logic      energy_pin,
  output logic      flp_loop_pin,
  output logic      link_pin,
  output logic      xover_pin,
  output logic      pol_pin
);
  import clp_pkg::*;
  logic [P_W-1:0] now_w;
  logic [P_W-1:0] pipe_q [DLY];

  // Unpowered partner echoes pulses; powered one links via negotiation
  assign now_w[P_NRG]  = plug & ~unpowered;
  assign now_w[P_LOOP] = plug & unpowered & flp_search_tx;
  assign now_w[P_LINK] = plug & ~unpowered & an_run;
  assign now_w[P_XOV]  = plug & crossed;
  assign now_w[P_POL]  = plug & inverted;

  // Slow answer so the searching status can be seen first
  always @(posedge clk) begin
    pipe_q[0] <= now_w;
    for (int i = 1; i < DLY; i++) begin
      pipe_q[i] <= pipe_q[i-1];
    end
  end

  assign {pol_pin, xover_pin, link_pin, flp_loop_pin, energy_pin} =
    (pipe_q[DLY-1] === 'x) ? '0 : pipe_q[DLY-1];
endmodule

// ---- testbench/clp_top_tb.sv ----
/*
  Self-checking bench for the copper link power control block.
  Assumes the media model on the pins and a 4-cycle millisecond.
*/
`timescale 1ns/10ps
`define CHK(a,e) begin n_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%0h exp=%0h", $time, a, e); end end
`define WT(c,n) begin wc = 0; while (!(c) && wc < (n)) begin \
  @(posedge clk); #1; wc++; end end
module clp_top_tb;
  import clp_pkg::*;
  localparam int PW = 30;
  logic          clk;
  logic          rst_n;
  logic [AW-1:0] reg_addr;
  logic [DW-1:0] reg_wdata;
  logic [DW-1:0] reg_rdata;
  logic [DW-1:0] rd_q;
  logic          reg_wr, reg_rd, speed_100, tx_lpi_req;
  logic          plug, unpowered, crossed, inverted, pair0;
  logic          energy_pin, flp_loop_pin, link_pin, xover_pin, pol_pin;
  logic          mdi_crossed, pol_correct, lowamp_10, lpi_active;
  logic          flp_search_tx, an_run, power_down, flp_burst;
  logic          wake_pair_b, det_irq;
  int            num_errors, n_checks, wc, cyc;
  logic [DW-1:0] xv_ctl [6] = '{16'h002F, 16'h003F, 16'h001F,
                                16'h000E, 16'h0006, 16'h000D};
  logic          xv_exp [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

  clp_top #(.MS_CYC_P(17'h00004)) uut (
    .clk(clk), .rst_n(rst_n), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .energy_pin(energy_pin),
    .flp_loop_pin(flp_loop_pin), .link_pin(link_pin),
    .xover_pin(xover_pin), .pol_pin(pol_pin), .speed_100(speed_100),
    .tx_lpi_req(tx_lpi_req), .mdi_crossed(mdi_crossed),
    .pol_correct(pol_correct), .lowamp_10(lowamp_10),
    .lpi_active(lpi_active), .flp_search_tx(flp_search_tx),
    .an_run(an_run), .power_down(power_down), .flp_burst(flp_burst),
    .wake_pair_b(wake_pair_b), .det_irq(det_irq)
  );

  clp_media_model #(.DLY(20)) partner (
    .clk(clk), .plug(plug), .unpowered(unpowered), .crossed(crossed),
    .inverted(inverted), .an_run(an_run), .flp_search_tx(flp_search_tx),
    .energy_pin(energy_pin), .flp_loop_pin(flp_loop_pin),
    .link_pin(link_pin), .xover_pin(xover_pin), .pol_pin(pol_pin)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [AW-1:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    rd_q = reg_rdata;
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Whole run needs about 20000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    rst_n = 1'b0; reg_addr = '0; reg_wdata = '0; reg_wr = 1'b0;
    reg_rd = 1'b0; speed_100 = 1'b0; tx_lpi_req = 1'b0; plug = 1'b1;
    unpowered = 1'b1; crossed = 1'b1; inverted = 1'b1;
    num_errors = 0; n_checks = 0; cyc = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    rd(A_CTRL); `CHK(rd_q, 16'h000F)
    rd(A_TSEL); `CHK(rd_q, 16'h0001)
    rd(3'h5); `CHK(rd_q, 16'h0000)
    cyc_n(PW);
    `CHK(mdi_crossed, 1'b1)
    `CHK(pol_correct, 1'b1)
    rd(A_STAT); `CHK(rd_q[1:0], 2'h3)
    foreach (xv_ctl[i]) begin
      wr(A_CTRL, xv_ctl[i]);
      cyc_n(3);
      `CHK(mdi_crossed, xv_exp[i])
    end
    @(posedge clk);
    crossed <= 1'b0;
    wr(A_CTRL, 16'h003F);
    cyc_n(PW); `CHK(mdi_crossed, 1'b1)
    wr(A_CTRL, 16'h004B);
    cyc_n(3);
    `CHK(lowamp_10, 1'b1)
    `CHK(pol_correct, 1'b0)
    wr(A_CTRL, 16'h010F);
    cyc_n(3); `CHK(flp_search_tx, 1'b1)
    rd(A_STAT); `CHK(rd_q[3:2], DST_SRCH)
    `WT(det_irq, 100)
    `CHK(det_irq, 1'b1)
    rd(A_STAT); `CHK(rd_q[3:2], DST_PWR)
    @(posedge clk);
    unpowered <= 1'b0;
    rd(A_FLAG); `CHK(rd_q, 16'h0001)
    rd(A_FLAG); `CHK(rd_q, 16'h0000)
    `CHK(det_irq, 1'b0)
    `CHK(an_run, 1'b0)
    `WT(an_run, 2200)
    `CHK(an_run, 1'b1)
    `CHK(flp_search_tx, 1'b0)
    rd(A_STAT); `CHK(rd_q[3:2], DST_NONE)
    cyc_n(PW);
    rd(A_STAT); `CHK(rd_q[S_LINK], 1'b1)
    wr(A_CTRL, 16'h018F);
    @(posedge clk);
    speed_100 <= 1'b1;
    tx_lpi_req <= 1'b1;
    cyc_n(3); `CHK(lpi_active, 1'b1)
    @(posedge clk);
    tx_lpi_req <= 1'b0;
    cyc_n(3); `CHK(lpi_active, 1'b0)
    @(posedge clk);
    plug <= 1'b0;
    unpowered <= 1'b1;
    cyc_n(PW);
    `CHK(an_run, 1'b0)
    `CHK(flp_search_tx, 1'b1)
    // Power management, all timers at their shortest codes
    wr(A_TSEL, 16'h0000);
    wr(A_CTRL, 16'h020F);
    `WT(power_down, 4600)
    `CHK(power_down, 1'b1)
    rd(A_CTRL); `CHK(rd_q, 16'h020F)
    rd(A_STAT); `CHK(rd_q[7:5], 3'h1)
    `WT(flp_burst, 4600)
    `CHK(flp_burst, 1'b1)
    `CHK(power_down, 1'b0)
    pair0 = wake_pair_b;
    `WT(wake_pair_b !== pair0, 200)
    `CHK(wake_pair_b, ~pair0)
    `CHK(flp_burst, 1'b1)
    `WT(!flp_burst, 300)
    `CHK(flp_burst, 1'b0)
    `WT(power_down, 600)
    `CHK(power_down, 1'b1)
    @(posedge clk);
    plug <= 1'b1;
    unpowered <= 1'b0;
    cyc_n(PW); `CHK(power_down, 1'b0)
    rd(A_STAT); `CHK(rd_q[7:5], 3'h4)
    cyc_n(PW);
    plug <= 1'b0;
    cyc_n(3800); `CHK(power_down, 1'b0)
    `WT(power_down, 400)
    `CHK(power_down, 1'b1)
    @(posedge clk);
    plug <= 1'b1;
    cyc_n(PW);
    wr(A_CTRL, 16'h020E);
    @(posedge clk);
    plug <= 1'b0;
    cyc_n(4600); `CHK(power_down, 1'b0)
    rd(A_STAT); `CHK(rd_q[7:5], 3'h4)
    end_of_test();
  end
endmodule
